// ---- logic/asf_pkg.sv ----
package asf_pkg;
   // Pin timing figures in ns, slowest speed grade
   localparam int CLK_PERIOD_NS = 40;
   localparam int PW_NS = 25;       // Strobe, reset and retransmit low width
   localparam int REC_NS = 10;      // Recovery after a strobe, reset or retransmit
   localparam int SETUP_HI_NS = 25; // Strobes high before reset release
   localparam int ACCESS_NS = 25;   // Read low to data valid
   localparam int FLAG_NS = 35;     // Worst flag settle time
   // Cycle counts: least times round up
   localparam int PW_CYC = (PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REC_CYC = (REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_HI_CYC = (SETUP_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLAG_CYC = (FLAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Width of the phase counter
   localparam int CNT_W = 4;
   // Synchroniser depth
   localparam int SYNC_STAGES = 2;
   // Register map, byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_WDATA = 4'h8;
   localparam logic [3:0] ADDR_RDATA = 4'hc;
   // Control register fields (reset and retransmit: write one to start)
   localparam int CTRL_RESET_BIT = 0;
   localparam int CTRL_RETX_BIT = 1;
   localparam int CTRL_DEPTH_BIT = 2; // Level: first_load_n driven low when set
   // Status register fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_EMPTY_N_BIT = 1;
   localparam int ST_HALF_N_BIT = 2;
   localparam int ST_FULL_N_BIT = 3;
   localparam int ST_RVALID_BIT = 4;
   localparam int ST_DROP_BIT = 5;
   localparam int ST_INIT_BIT = 6;
   // Sequencer states
   typedef enum logic [2:0] {
      ASF_IDLE,
      ASF_RST_LOW,
      ASF_RST_REC,
      ASF_WR_LOW,
      ASF_RD_LOW,
      ASF_RT_LOW,
      ASF_RECOVER
   } asf_state_t;
endpackage : asf_pkg

// ---- logic/asf_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
// Two flip-flop synchroniser per bit for the flag pins
module asf_sync #(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Async levels in, synced levels out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   initial
   begin
      if (WIDTH < 1)
      begin
         $error("asf_sync: WIDTH must be at least one");
      end
   end

   // First stage feeds only the second
   always_comb
   begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // Reset to the flags' idle level
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_q <= INIT;
         sync_q <= INIT;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule : asf_sync
`default_nettype wire

// ---- logic/asf_ctrl.sv ----
// How it works
// - Master reset before any write or read
// - Strobes high around master reset release
// - Data held stable around write strobe rise while ADDR_WDATA is not written during the strobe
// - Strobes high during and after retransmit
// - Standalone: chain low, first-load high
// - Width chains share all control lines
// - Depth ring: first-load low starts loading
`timescale 1ns/1ns
`default_nettype none
module asf_ctrl #(
   parameter int DATA_W = 9
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Software register port
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // Buffer strobes and controls
   output logic write_n_out,
   output logic read_n_out,
   output logic master_reset_n_out,
   output logic retransmit_n_out,
   output logic first_load_n_out,
   output logic chain_in_n_out,
   // Buffer data pins
   output logic [DATA_W-1:0] wr_data_out,
   input wire logic [DATA_W-1:0] rd_data_in,
   // Buffer flag pins
   input wire logic empty_flag_n_in,
   input wire logic half_full_flag_n_in,
   input wire logic full_flag_n_in
);
   initial
   begin
      if (DATA_W < 9 || DATA_W > 27 || DATA_W % 9 != 0)
      begin
         $error("asf_ctrl: DATA_W must be 9, 18 or 27");
      end
   end

   // Flag pins come from another domain
   logic [2:0] flags_sync;
   logic empty_n;
   logic half_n;
   logic full_n;

   asf_sync #(
      .WIDTH(3),
      .INIT(3'h7)
   ) u_flag_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .async_in({full_flag_n_in, half_full_flag_n_in, empty_flag_n_in}),
      .sync_out(flags_sync)
   );

   assign empty_n = flags_sync[0];
   assign half_n = flags_sync[1];
   assign full_n = flags_sync[2];

   // Sequencer and pin state
   asf_pkg::asf_state_t state_q, state_d;
   logic [asf_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic init_q, init_d;
   logic drop_q, drop_d;
   logic rvalid_q, rvalid_d;
   logic depth_q, depth_d;
   logic wpend_q, wpend_d;
   logic rpend_q, rpend_d;
   logic rstpend_q, rstpend_d;
   logic rtpend_q, rtpend_d;
   logic [DATA_W-1:0] wdat_q, wdat_d;
   logic [DATA_W-1:0] rdat_q, rdat_d;
   logic [DATA_W-1:0] rcap_q, rcap_d;
   logic [DATA_W-1:0] rcap2_q, rcap2_d;
   logic write_n_q, write_n_d;
   logic read_n_q, read_n_d;
   logic mr_n_q, mr_n_d;
   logic rt_n_q, rt_n_d;
   logic [31:0] rdata_q, rdata_d;
   logic busy;

   assign busy = (state_q != asf_pkg::ASF_IDLE);

   // Phase counter sized for the longest wait
   localparam logic [asf_pkg::CNT_W-1:0] PW_C = asf_pkg::CNT_W'(asf_pkg::PW_CYC);
   localparam logic [asf_pkg::CNT_W-1:0] REC_C =
      asf_pkg::CNT_W'(asf_pkg::REC_CYC + asf_pkg::FLAG_CYC + asf_pkg::SYNC_STAGES);
   localparam logic [asf_pkg::CNT_W-1:0] SETUP_C = asf_pkg::CNT_W'(asf_pkg::SETUP_HI_CYC);
   localparam logic [asf_pkg::CNT_W-1:0] RD_C =
      asf_pkg::CNT_W'(asf_pkg::ACCESS_CYC + asf_pkg::SYNC_STAGES);

   // Sequencer next state
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      init_d = init_q;
      drop_d = drop_q;
      rvalid_d = rvalid_q;
      depth_d = depth_q;
      wpend_d = wpend_q;
      rpend_d = rpend_q;
      rstpend_d = rstpend_q;
      rtpend_d = rtpend_q;
      wdat_d = wdat_q;
      rdat_d = rdat_q;
      rcap_d = rcap_q;
      rcap2_d = rcap2_q;
      write_n_d = write_n_q;
      read_n_d = read_n_q;
      mr_n_d = mr_n_q;
      rt_n_d = rt_n_q;
      rdata_d = 32'h0;
      // Register writes queue requests; a busy sequencer takes them later
      if (wr_in)
      begin
         unique case (addr_in)
            asf_pkg::ADDR_CTRL:
            begin
               if (wdata_in[asf_pkg::CTRL_RESET_BIT])
               begin
                  rstpend_d = 1'b1;
               end
               if (wdata_in[asf_pkg::CTRL_RETX_BIT] && !depth_q)
               begin
                  rtpend_d = 1'b1;
               end
               // Mode pin moves only apart from a reset start, so it is settled first
               if (!busy && !wdata_in[asf_pkg::CTRL_RESET_BIT])
               begin
                  depth_d = wdata_in[asf_pkg::CTRL_DEPTH_BIT];
               end
               drop_d = 1'b0;
            end
            asf_pkg::ADDR_WDATA:
            begin
               wdat_d = wdata_in[DATA_W-1:0];
               wpend_d = 1'b1;
            end
            asf_pkg::ADDR_RDATA:
            begin
               rpend_d = 1'b1;
            end
            default:
            begin
            end
         endcase
      end
      if (rd_in)
      begin
         unique case (addr_in)
            asf_pkg::ADDR_CTRL:
               rdata_d = {29'h0, depth_q, 2'h0};
            asf_pkg::ADDR_STATUS:
               rdata_d = {25'h0, init_q, drop_q, rvalid_q, full_n, half_n, empty_n, busy};
            asf_pkg::ADDR_RDATA:
            begin
               rdata_d = {{(32 - DATA_W){1'b0}}, rdat_q};
               rvalid_d = 1'b0;
            end
            default:
               rdata_d = 32'h0;
         endcase
      end
      unique case (state_q)
         asf_pkg::ASF_IDLE:
         begin
            cnt_d = '0;
            if (rstpend_q || rstpend_d)
            begin
               // Strobes are already high in idle for the setup time
               rstpend_d = 1'b0;
               mr_n_d = 1'b0;
               init_d = 1'b0;
               wpend_d = 1'b0;
               rpend_d = 1'b0;
               rtpend_d = 1'b0;
               state_d = asf_pkg::ASF_RST_LOW;
            end
            else if (!init_q)
            begin
               wpend_d = 1'b0;
               rpend_d = 1'b0;
               rtpend_d = 1'b0;
            end
            else if (rtpend_q)
            begin
               rtpend_d = 1'b0;
               rt_n_d = 1'b0;
               state_d = asf_pkg::ASF_RT_LOW;
            end
            else if (wpend_q)
            begin
               wpend_d = 1'b0;
               if (!full_n)
               begin
                  drop_d = 1'b1;
               end
               else
               begin
                  write_n_d = 1'b0;
                  state_d = asf_pkg::ASF_WR_LOW;
               end
            end
            else if (rpend_q)
            begin
               rpend_d = 1'b0;
               if (!empty_n)
               begin
                  drop_d = 1'b1;
               end
               else
               begin
                  read_n_d = 1'b0;
                  state_d = asf_pkg::ASF_RD_LOW;
               end
            end
         end
         asf_pkg::ASF_RST_LOW:
         begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q + 1'b1 >= PW_C)
            begin
               mr_n_d = 1'b1;
               cnt_d = '0;
               state_d = asf_pkg::ASF_RST_REC;
            end
         end
         asf_pkg::ASF_RST_REC:
         begin
            // Strobes stay high through recovery and flag settle
            cnt_d = cnt_q + 1'b1;
            if (cnt_q + 1'b1 >= REC_C)
            begin
               init_d = 1'b1;
               rvalid_d = 1'b0;
               cnt_d = '0;
               state_d = asf_pkg::ASF_IDLE;
            end
         end
         asf_pkg::ASF_WR_LOW:
         begin
            // Data held from before the fall until after the rise, unless ADDR_WDATA is written while busy
            cnt_d = cnt_q + 1'b1;
            if (cnt_q + 1'b1 >= PW_C)
            begin
               write_n_d = 1'b1;
               cnt_d = '0;
               state_d = asf_pkg::ASF_RECOVER;
            end
         end
         asf_pkg::ASF_RD_LOW:
         begin
            // Pulse held past access time, data sampled through two stages
            cnt_d = cnt_q + 1'b1;
            rcap_d = rd_data_in;
            rcap2_d = rcap_q;
            if (cnt_q + 1'b1 >= RD_C)
            begin
               rdat_d = rcap2_q;
               rvalid_d = 1'b1;
               read_n_d = 1'b1;
               cnt_d = '0;
               state_d = asf_pkg::ASF_RECOVER;
            end
         end
         asf_pkg::ASF_RT_LOW:
         begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q + 1'b1 >= PW_C)
            begin
               rt_n_d = 1'b1;
               cnt_d = '0;
               state_d = asf_pkg::ASF_RECOVER;
            end
         end
         asf_pkg::ASF_RECOVER:
         begin
            // Flags must settle and pass the synchroniser before reuse
            cnt_d = cnt_q + 1'b1;
            if (cnt_q + 1'b1 >= REC_C)
            begin
               cnt_d = '0;
               state_d = asf_pkg::ASF_IDLE;
            end
         end
         default:
         begin
            state_d = asf_pkg::ASF_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_q <= asf_pkg::ASF_IDLE;
         cnt_q <= '0;
         init_q <= 1'b0;
         drop_q <= 1'b0;
         rvalid_q <= 1'b0;
         depth_q <= 1'b0;
         wpend_q <= 1'b0;
         rpend_q <= 1'b0;
         rstpend_q <= 1'b1;
         rtpend_q <= 1'b0;
         wdat_q <= '0;
         rdat_q <= '0;
         rcap_q <= '0;
         rcap2_q <= '0;
         write_n_q <= 1'b1;
         read_n_q <= 1'b1;
         mr_n_q <= 1'b1;
         rt_n_q <= 1'b1;
         rdata_q <= 32'h0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         init_q <= init_d;
         drop_q <= drop_d;
         rvalid_q <= rvalid_d;
         depth_q <= depth_d;
         wpend_q <= wpend_d;
         rpend_q <= rpend_d;
         rstpend_q <= rstpend_d;
         rtpend_q <= rtpend_d;
         wdat_q <= wdat_d;
         rdat_q <= rdat_d;
         rcap_q <= rcap_d;
         rcap2_q <= rcap2_d;
         write_n_q <= write_n_d;
         read_n_q <= read_n_d;
         mr_n_q <= mr_n_d;
         rt_n_q <= rt_n_d;
         rdata_q <= rdata_d;
      end
   end

   // Pins straight from flops; chain input grounded for standalone
   assign write_n_out = write_n_q;
   assign read_n_out = read_n_q;
   assign master_reset_n_out = mr_n_q;
   assign retransmit_n_out = rt_n_q;
   assign first_load_n_out = ~depth_q;
   assign chain_in_n_out = 1'b0;
   assign wr_data_out = wdat_q;
   assign rdata_out = rdata_q;
endmodule : asf_ctrl
`default_nettype wire

// ---- tb/asf_ctrl_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module asf_ctrl_monitor #(
   parameter int DATA_W = 9
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Buffer strobes, mode pins and write data
   input wire logic write_n_out,
   input wire logic read_n_out,
   input wire logic master_reset_n_out,
   input wire logic retransmit_n_out,
   input wire logic first_load_n_out,
   input wire logic chain_in_n_out,
   input wire logic [DATA_W-1:0] wr_data_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   logic init_q;
   logic init_d;
   // Set once the buffer has seen its first reset
   always_comb init_d = init_q | ~master_reset_n_out;
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         init_q <= 1'b0;
      else
         init_q <= init_d;
   end
   // Buffer reset follows controller reset within two cycles
   property p_mr_first;
      $fell(rst_in) |-> ##[0:2] !master_reset_n_out;
   endproperty
   a_mr_first: assert property (p_mr_first) else $error("no buffer reset");
   property p_pre_init;
      !init_q |-> write_n_out && read_n_out;
   endproperty
   a_pre_init: assert property (p_pre_init) else $error("strobe before reset");
   // Strobes idle around reset release
   property p_mr_rel;
      $rose(master_reset_n_out) |-> ($past(write_n_out) && $past(read_n_out)
         && write_n_out && read_n_out) ##1 (write_n_out && read_n_out);
   endproperty
   a_mr_rel: assert property (p_mr_rel) else $error("strobe near reset");
   // Strobes idle during and after a rewind
   property p_rt_low;
      !retransmit_n_out |-> write_n_out && read_n_out;
   endproperty
   a_rt_low: assert property (p_rt_low) else $error("strobe in rewind");
   property p_rt_rec;
      $rose(retransmit_n_out) |-> (write_n_out && read_n_out) [*2];
   endproperty
   a_rt_rec: assert property (p_rt_rec) else $error("strobe after rewind");
   // Chain input held low, first load steady over reset
   property p_mode;
      !master_reset_n_out |-> !chain_in_n_out && $stable(first_load_n_out);
   endproperty
   a_mode: assert property (p_mode) else $error("mode pins moved");
   // Write data steady through the strobe and its rise
   property p_wd_low;
      !write_n_out |-> $stable(wr_data_out);
   endproperty
   a_wd_low: assert property (p_wd_low) else $error("data moved");
   property p_wd_hold;
      $fell(write_n_out) |-> ##1 (write_n_out && $stable(wr_data_out));
   endproperty
   a_wd_hold: assert property (p_wd_hold) else $error("data not held");
endmodule : asf_ctrl_monitor
bind asf_ctrl asf_ctrl_monitor #(.DATA_W(DATA_W)) i_mon (.clk_in(clk_in), .rst_in(rst_in),
   .write_n_out(write_n_out), .read_n_out(read_n_out),
   .master_reset_n_out(master_reset_n_out), .retransmit_n_out(retransmit_n_out),
   .first_load_n_out(first_load_n_out), .chain_in_n_out(chain_in_n_out),
   .wr_data_out(wr_data_out));
`default_nettype wire

// ---- tb/asf_fifo_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module asf_fifo_model #(
   parameter int DEPTH = 8
) (
   // Strobes
   input wire logic master_reset_n_in,
   input wire logic write_n_in,
   input wire logic read_n_in,
   input wire logic retransmit_n_in,
   // Data
   input wire logic [8:0] data_in,
   output logic [8:0] data_out,
   // Flags
   output logic empty_flag_n_out,
   output logic half_full_flag_n_out,
   output logic full_flag_n_out
);
   logic [8:0] mem [DEPTH];
   int wr_ptr = 0;
   int rd_ptr = 0;
   int count = 0;
   logic wr_ok = 1'b0;
   logic rd_ok = 1'b0;
   // Flags straight from the fill level
   task automatic set_flags();
      empty_flag_n_out = (count != 0);
      half_full_flag_n_out = (count <= DEPTH / 2);
      full_flag_n_out = (count != DEPTH);
   endtask : set_flags
   initial set_flags();
   // Reset empties the store
   always @(negedge master_reset_n_in)
   begin
      wr_ptr = 0;
      rd_ptr = 0;
      count = 0;
      set_flags();
   end
   // Rewind; level assumes no wrap since reset
   always @(negedge retransmit_n_in)
   begin
      rd_ptr = 0;
      count = wr_ptr;
      set_flags();
   end
   // Write flags fall on strobe fall, word lands on rise
   always @(negedge write_n_in)
   begin
      wr_ok = full_flag_n_out;
      if (wr_ok && count + 1 == DEPTH) full_flag_n_out = 1'b0;
      if (wr_ok && count + 1 > DEPTH / 2) half_full_flag_n_out = 1'b0;
   end
   always @(posedge write_n_in)
   begin
      if (wr_ok)
      begin
         mem[wr_ptr] = data_in;
         wr_ptr = (wr_ptr + 1) % DEPTH;
         count++;
         empty_flag_n_out = 1'b1;
      end
      wr_ok = 1'b0;
   end
   // Reads refused while empty
   always @(negedge read_n_in)
   begin
      rd_ok = empty_flag_n_out;
      if (rd_ok && count == 1) empty_flag_n_out = 1'b0;
   end
   always @(posedge read_n_in)
   begin
      if (rd_ok)
      begin
         rd_ptr = (rd_ptr + 1) % DEPTH;
         count--;
         full_flag_n_out = 1'b1;
         if (count == DEPTH / 2) half_full_flag_n_out = 1'b1;
      end
      rd_ok = 1'b0;
   end
   // Bus floats outside a valid read
   assign data_out = (!read_n_in && rd_ok) ? mem[rd_ptr] : 'z;
endmodule : asf_fifo_model
`default_nettype wire

// ---- tb/async_strobe_fifo_9bit_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module async_strobe_fifo_9bit_tb;
   localparam int DEPTH = 8;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] d;
   wire [31:0] rdata;
   wire wn, rn, mrn, rtn, ef, hf, ff, fl, xi;
   wire [8:0] wd, qd;
   int bad_count = 0;
   int num_checks = 0;
   // 25 MHz
   initial forever #20 clk_in = ~clk_in;
   asf_ctrl i_asf_ctrl (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .write_n_out(wn), .read_n_out(rn),
      .master_reset_n_out(mrn), .retransmit_n_out(rtn), .first_load_n_out(fl),
      .chain_in_n_out(xi), .wr_data_out(wd), .rd_data_in(qd), .empty_flag_n_in(ef),
      .half_full_flag_n_in(hf), .full_flag_n_in(ff));
   asf_fifo_model #(.DEPTH(DEPTH)) i_asf_fifo_model (.master_reset_n_in(mrn),
      .write_n_in(wn), .read_n_in(rn), .retransmit_n_in(rtn), .data_in(wd), .data_out(qd),
      .empty_flag_n_out(ef), .half_full_flag_n_out(hf), .full_flag_n_out(ff));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Register port: one-cycle strobes, a gap cycle after each
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
      @(posedge clk_in);
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk_in);
   endtask : reg_rd
   // Lets the request reach the sequencer, then polls busy
   task automatic idle();
      repeat (3) @(posedge clk_in);
      for (int i = 0; i < 40; i++)
      begin
         reg_rd(asf_pkg::ADDR_STATUS);
         if (d[asf_pkg::ST_BUSY_BIT] === 1'b0)
            return;
      end
      chk("busy", d, 32'h0);
   endtask : idle
   task automatic st(input logic dr, input logic fn, input logic hn, input logic en);
      reg_rd(asf_pkg::ADDR_STATUS);
      chk("status", {d[6:5], d[3:1]}, {1'b1, dr, fn, hn, en});
   endtask : st
   task automatic fwr(input logic [31:0] v);
      reg_wr(asf_pkg::ADDR_WDATA, v);
      idle();
   endtask : fwr
   task automatic frd();
      reg_wr(asf_pkg::ADDR_RDATA, 32'h0);
      idle();
      reg_rd(asf_pkg::ADDR_RDATA);
   endtask : frd
   function automatic logic [31:0] pat(input int k);
      return 32'(k * 37 + 101) & 32'h1ff;
   endfunction : pat
   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      idle();
      st(0, 1, 1, 0);
      frd();
      st(1, 1, 1, 0);
      reg_wr(asf_pkg::ADDR_CTRL, 32'h0);
      for (int k = 0; k < DEPTH; k++)
      begin
         fwr(pat(k));
         st(0, k < DEPTH - 1, k < DEPTH / 2, 1);
      end
      fwr(32'h1ff);
      st(1, 0, 0, 1);
      reg_wr(asf_pkg::ADDR_CTRL, 32'h0);
      for (int k = 0; k < DEPTH; k++)
      begin
         frd();
         chk("data", d & 32'h1ff, pat(k));
         st(0, 1, DEPTH - k - 1 <= DEPTH / 2, k < DEPTH - 1);
      end
      // Reset with a word stored, then rewind and append
      fwr(pat(20));
      reg_wr(asf_pkg::ADDR_CTRL, 32'h1);
      idle();
      st(0, 1, 1, 0);
      for (int k = 0; k < 3; k++)
         fwr(pat(k + 8));
      frd();
      frd();
      reg_wr(asf_pkg::ADDR_CTRL, 32'h2);
      idle();
      st(0, 1, 1, 1);
      fwr(pat(11));
      for (int k = 0; k < 4; k++)
      begin
         frd();
         chk("replay", d & 32'h1ff, pat(k + 8));
      end
      st(0, 1, 1, 0);
      // Depth level drives first load low; rewind is refused there
      chk("chain", {31'h0, xi}, 32'h0);
      chk("first", {31'h0, fl}, 32'h1);
      reg_wr(asf_pkg::ADDR_CTRL, 32'h4);
      reg_rd(asf_pkg::ADDR_CTRL);
      chk("ctrl", d, 32'h4);
      chk("first", {31'h0, fl}, 32'h0);
      reg_wr(asf_pkg::ADDR_CTRL, 32'h6);
      repeat (3) @(posedge clk_in);
      chk("rewind", {31'h0, rtn}, 32'h1);
      reg_wr(asf_pkg::ADDR_CTRL, 32'h0);
      chk("first", {31'h0, fl}, 32'h1);
      tally_and_finish();
   end
   // Whole run needs a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge clk_in);
      bad_count++;
      tally_and_finish();
   end
endmodule : async_strobe_fifo_9bit_tb
`default_nettype wire
